// ===== ipc_power_ctrl.sv
// Idle and power-down controller with an APB register slave.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - clear watchdog on entering and leaving low power
// - power-down bit stops CPU and peripheral clocks
// - power-down wake clears bit, runs waking service
// - both bits set means power-down, never idle
// - idle bit stops only the CPU clock
// - idle holds CPU state and port levels
// - writing instruction is last before gating
// - enabled interrupt ends idle, clears idle bit
// - non-software resets end idle
// - power-down bit write enters power-down
// - power-down stops oscillator and flash
// - non-software resets and brown-out end power-down
// - pin or power-on reset restarts CPU cold
// - enabled external pin edge wakes power-down
// - brown-out, watchdog, keyboard wake power-down
// - keyboard wake only on opposite edge
// - power-on completion sets cold start flag
module ipc_power_ctrl #(
	parameter int KEY_W = 8,
	parameter int EXT_W = 2
) (
	// APB slave.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ipc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output var logic [31:0] prdata,
	output var logic pready,
	output var logic pslverr,
	// Wake sources.
	input wire logic [EXT_W-1:0] ext_int,
	input wire logic [EXT_W-1:0] ext_int_en,
	input wire logic global_int_enable,
	input wire logic [KEY_W-1:0] keyboard_interrupt,
	input wire logic wdt_irq,
	input wire logic bod_irq,
	input wire logic irq_pending,
	// Reset sources.
	input wire logic pin_reset,
	input wire logic por_reset,
	input wire logic wdt_reset,
	input wire logic bod_reset,
	input wire logic soft_reset,
	input wire logic por_done,
	// Clock system and core control.
	output var ipc_pkg::ipc_clk_ctl_t clk_ctl,
	output var logic watchdog_counter_clear,
	output var ipc_pkg::ipc_wake_src_t wake_src,
	output var logic cold_init,
	output var logic [7:0] power_control,
	output var logic irq
);
	if (KEY_W < 1 || KEY_W > 8 || EXT_W < 1 || EXT_W > 8) begin : g_chk
		$error("ipc_power_ctrl: KEY_W and EXT_W must be 1 to 8");
	end

	// ****************************************
	// APB decode.
	// ****************************************
	logic setup;
	logic access;
	logic hit;
	logic wr;
	logic wr_pc;
	logic [31:0] rd_mux;
	ipc_pkg::ipc_state_t state_reg;
	ipc_pkg::ipc_state_t state_next;
	logic [ipc_pkg::ST_W-1:0] status_reg;
	logic [ipc_pkg::ST_W-1:0] status_next;
	logic [ipc_pkg::ST_W-1:0] enable_reg;
	logic [7:0] key_mask_reg;

	assign setup = psel & ~penable;
	assign access = psel & penable & pready;
	assign wr = access & pwrite & ~pslverr;
	assign wr_pc = wr & (paddr == ipc_pkg::POWER_CONTROL_ADDR);

	always_comb begin
		hit = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			ipc_pkg::POWER_CONTROL_ADDR: rd_mux[7:0] = power_control;
			ipc_pkg::IRQ_STATUS_ADDR: rd_mux[ipc_pkg::ST_W-1:0] = status_reg;
			ipc_pkg::IRQ_CLEAR_ADDR: rd_mux = 32'h0000_0000;
			ipc_pkg::IRQ_ENABLE_ADDR: rd_mux[ipc_pkg::ST_W-1:0] = enable_reg;
			ipc_pkg::KEY_MASK_ADDR: rd_mux[7:0] = key_mask_reg;
			default: hit = 1'b0;
		endcase
	end

	// One wait-free access phase: pready is raised by the setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup;
			pslverr <= setup & ~hit;
			if (setup) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_mux;
			end
		end
	end

	// ****************************************
	// Wake detection.
	// ****************************************
	logic [EXT_W-1:0] ext_prev_reg;
	logic [KEY_W-1:0] key_prev_reg;
	logic [KEY_W-1:0] key_ref_reg;
	logic ext_wake;
	logic key_wake;
	logic pd_wake;
	logic idle_wake;
	logic hard_rst;
	logic cold_rst;
	logic entering;
	logic leaving;

	assign ext_wake = global_int_enable & |(ext_int & ~ext_prev_reg & ext_int_en);
	// A pin low at entry wakes only on a rise, a pin high only on a fall.
	assign key_wake = |((keyboard_interrupt ^ key_prev_reg)
		& (keyboard_interrupt ^ key_ref_reg) & key_mask_reg[KEY_W-1:0]);
	assign pd_wake = ext_wake | key_wake | wdt_irq | bod_irq;
	assign idle_wake = pd_wake | irq_pending;
	// A software reset cannot end a low-power state.
	assign cold_rst = pin_reset | por_reset;
	assign hard_rst = cold_rst | wdt_reset | bod_reset;
	assign entering = (state_reg == ipc_pkg::ST_RUN) && (state_next != ipc_pkg::ST_RUN);
	assign leaving = (state_reg != ipc_pkg::ST_RUN) && (state_next == ipc_pkg::ST_RUN);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_prev_reg <= '0;
			key_prev_reg <= '0;
		end else begin
			ext_prev_reg <= ext_int;
			key_prev_reg <= keyboard_interrupt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_ref_reg <= '0;
		end else if (entering) begin
			key_ref_reg <= keyboard_interrupt;
		end
	end

	// ****************************************
	// Power state machine.
	// ****************************************
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ipc_pkg::ST_RUN: begin
				if (wr_pc && pwdata[ipc_pkg::PD_BIT]) begin
					state_next = ipc_pkg::ST_PDOWN;
				end else if (wr_pc && pwdata[ipc_pkg::IDLE_BIT]) begin
					state_next = ipc_pkg::ST_IDLE;
				end
			end
			ipc_pkg::ST_IDLE: begin
				if (idle_wake || hard_rst) begin
					state_next = ipc_pkg::ST_RUN;
				end
			end
			ipc_pkg::ST_PDOWN: begin
				if (pd_wake || hard_rst) begin
					state_next = ipc_pkg::ST_RUN;
				end
			end
			default: state_next = ipc_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ipc_pkg::ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// Gating follows the writing access edge, so that access is the last one run.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_ctl <= ipc_pkg::CLK_CTL_RESET;
		end else begin
			clk_ctl.cpu_clk_en <= (state_next == ipc_pkg::ST_RUN);
			clk_ctl.periph_clk_en <= (state_next != ipc_pkg::ST_PDOWN);
			clk_ctl.flash_en <= (state_next != ipc_pkg::ST_PDOWN);
			clk_ctl.osc_en <= (state_next != ipc_pkg::ST_PDOWN);
			clk_ctl.hold_pc <= (state_next != ipc_pkg::ST_RUN);
			clk_ctl.freeze_ports <= (state_next != ipc_pkg::ST_RUN);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_counter_clear <= 1'b0;
		end else begin
			watchdog_counter_clear <= entering | leaving;
		end
	end

	// The core runs the service routine of the flagged source and then resumes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_src <= '0;
			cold_init <= 1'b0;
		end else begin
			wake_src <= '0;
			cold_init <= leaving & cold_rst;
			if (leaving && !cold_rst) begin
				wake_src.ext <= ext_wake;
				wake_src.key <= key_wake;
				wake_src.wdt <= wdt_irq;
				wake_src.brown_out_detect <= bod_irq;
				wake_src.pending <= irq_pending & (state_reg == ipc_pkg::ST_IDLE);
				wake_src.warm_reset <= wdt_reset | bod_reset;
			end
		end
	end

	// ****************************************
	// Power control register.
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_control <= ipc_pkg::POWER_CONTROL_RESET;
		end else begin
			if (wr_pc) begin
				power_control <= pwdata[7:0] & ipc_pkg::POWER_CONTROL_WMASK;
			end
			if (leaving) begin
				power_control[ipc_pkg::PD_BIT] <= 1'b0;
				power_control[ipc_pkg::IDLE_BIT] <= 1'b0;
			end
			if (por_done) begin
				power_control[ipc_pkg::COLD_BIT] <= 1'b1;
			end
		end
	end

	// ****************************************
	// Interrupt status, clear and enable.
	// ****************************************
	always_comb begin
		status_next = status_reg;
		if (wr && paddr == ipc_pkg::IRQ_CLEAR_ADDR) begin
			status_next = status_reg & ~pwdata[ipc_pkg::ST_W-1:0];
		end
		status_next[ipc_pkg::ST_ENTER_BIT] = status_next[ipc_pkg::ST_ENTER_BIT] | entering;
		status_next[ipc_pkg::ST_WAKE_BIT] = status_next[ipc_pkg::ST_WAKE_BIT] | leaving;
		status_next[ipc_pkg::ST_COLD_BIT] = status_next[ipc_pkg::ST_COLD_BIT] | por_done;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= ipc_pkg::ST_RESET;
			irq <= 1'b0;
		end else begin
			status_reg <= status_next;
			irq <= |(status_next & enable_reg);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_reg <= ipc_pkg::ST_RESET;
			key_mask_reg <= ipc_pkg::KEY_MASK_RESET;
		end else if (wr) begin
			if (paddr == ipc_pkg::IRQ_ENABLE_ADDR) begin
				enable_reg <= pwdata[ipc_pkg::ST_W-1:0];
			end
			if (paddr == ipc_pkg::KEY_MASK_ADDR) begin
				key_mask_reg <= pwdata[7:0];
			end
		end
	end

	// ****************************************
	// Assertions.
	// ****************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic run_wr_pd;
	logic run_wr_idle;
	assign run_wr_pd = (state_reg == ipc_pkg::ST_RUN) && wr_pc && pwdata[ipc_pkg::PD_BIT];
	assign run_wr_idle = (state_reg == ipc_pkg::ST_RUN) && wr_pc
		&& pwdata[ipc_pkg::IDLE_BIT] && !pwdata[ipc_pkg::PD_BIT];

	property p_wdt_enter;
		run_wr_pd || run_wr_idle |=> watchdog_counter_clear
			##1 (!watchdog_counter_clear || state_reg == ipc_pkg::ST_RUN);
	endproperty
	a_wdt_enter: assert property (p_wdt_enter) else $error("watchdog not cleared on entry");

	property p_pd_clocks;
		run_wr_pd |=> !clk_ctl.cpu_clk_en && !clk_ctl.periph_clk_en && !clk_ctl.osc_en
			&& !clk_ctl.flash_en && clk_ctl.hold_pc;
	endproperty
	a_pd_clocks: assert property (p_pd_clocks) else $error("power-down left clocks on");

	property p_pd_wake;
		state_reg == ipc_pkg::ST_PDOWN && pd_wake && !hard_rst && !wr_pc |=>
			clk_ctl.cpu_clk_en && !power_control[ipc_pkg::PD_BIT]
			&& !power_control[ipc_pkg::IDLE_BIT] && watchdog_counter_clear;
	endproperty
	a_pd_wake: assert property (p_pd_wake) else $error("power-down wake wrong");

	property p_both_bits;
		run_wr_pd && pwdata[ipc_pkg::IDLE_BIT] |=> state_reg == ipc_pkg::ST_PDOWN;
	endproperty
	a_both_bits: assert property (p_both_bits) else $error("both bits did not pick power-down");

	property p_idle_clocks;
		run_wr_idle |=> (!clk_ctl.cpu_clk_en && clk_ctl.periph_clk_en)
			throughout (state_reg == ipc_pkg::ST_IDLE)[*1];
	endproperty
	a_idle_clocks: assert property (p_idle_clocks) else $error("idle gated wrong clocks");

	property p_idle_exit;
		state_reg == ipc_pkg::ST_IDLE && (irq_pending || wdt_reset) |=>
			state_reg == ipc_pkg::ST_RUN ##1 clk_ctl.cpu_clk_en;
	endproperty
	a_idle_exit: assert property (p_idle_exit) else $error("idle not ended");

	property p_cold;
		state_reg == ipc_pkg::ST_PDOWN && pin_reset |=> cold_init ##1 !cold_init;
	endproperty
	a_cold: assert property (p_cold) else $error("cold restart missing");

	property p_ext;
		state_reg == ipc_pkg::ST_PDOWN && ext_wake && !cold_rst |=> wake_src.ext;
	endproperty
	a_ext: assert property (p_ext) else $error("external wake not flagged");

	property p_key_same;
		state_reg == ipc_pkg::ST_PDOWN && !ext_wake && !wdt_irq && !bod_irq && !hard_rst
			&& ((keyboard_interrupt ^ key_ref_reg) == '0) |=> state_reg == ipc_pkg::ST_PDOWN;
	endproperty
	a_key_same: assert property (p_key_same) else $error("keyboard woke on wrong edge");

	property p_cold_flag;
		por_done |=> power_control[ipc_pkg::COLD_BIT] && status_reg[ipc_pkg::ST_COLD_BIT];
	endproperty
	a_cold_flag: assert property (p_cold_flag) else $error("cold start flag not set");

	c_idle_cycle: cover property (run_wr_idle ##[1:50] leaving);
	c_pd_key: cover property (state_reg == ipc_pkg::ST_PDOWN && key_wake);
	c_pd_reset: cover property (state_reg == ipc_pkg::ST_PDOWN && cold_rst);
	c_irq: cover property ($rose(irq));
endmodule // ipc_power_ctrl
`default_nettype wire

// ===== ipc_pkg.sv
// Constants and types of the idle and power-down controller.
`default_nettype none
package ipc_pkg;
	// ****************************************
	// Register map.
	// ****************************************
	localparam int ADDR_W = 12;
	localparam logic [9:0] POWER_CONTROL_IDX = 10'h087;
	localparam logic [9:0] IRQ_STATUS_IDX = 10'h088;
	localparam logic [9:0] IRQ_CLEAR_IDX = 10'h089;
	localparam logic [9:0] IRQ_ENABLE_IDX = 10'h08a;
	localparam logic [9:0] KEY_MASK_IDX = 10'h08b;
	localparam logic [ADDR_W-1:0] POWER_CONTROL_ADDR = {POWER_CONTROL_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = {IRQ_STATUS_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] IRQ_CLEAR_ADDR = {IRQ_CLEAR_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR = {IRQ_ENABLE_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] KEY_MASK_ADDR = {KEY_MASK_IDX, 2'b00};

	// ****************************************
	// Power control fields.
	// ****************************************
	localparam int IDLE_BIT = 0;
	localparam int PD_BIT = 1;
	localparam int GFL_BIT = 2;
	localparam int GFH_BIT = 3;
	localparam int COLD_BIT = 4;
	localparam int FRAME_SEL_BIT = 6;
	localparam int RATE_DBL_BIT = 7;
	localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
	localparam logic [7:0] POWER_CONTROL_WMASK = 8'hdf;

	// ****************************************
	// Interrupt status fields.
	// ****************************************
	localparam int ST_W = 3;
	localparam int ST_ENTER_BIT = 0;
	localparam int ST_WAKE_BIT = 1;
	localparam int ST_COLD_BIT = 2;
	localparam logic [ST_W-1:0] ST_RESET = 3'h0;
	localparam logic [7:0] KEY_MASK_RESET = 8'h00;

	// ****************************************
	// Types.
	// ****************************************
	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_IDLE = 3'b010,
		ST_PDOWN = 3'b100
	} ipc_state_t;

	typedef struct packed {
		logic osc_en;
		logic flash_en;
		logic periph_clk_en;
		logic cpu_clk_en;
		logic hold_pc;
		logic freeze_ports;
	} ipc_clk_ctl_t;

	localparam ipc_clk_ctl_t CLK_CTL_RESET = 6'h3c;

	typedef struct packed {
		logic ext;
		logic key;
		logic wdt;
		logic brown_out_detect;
		logic pending;
		logic warm_reset;
	} ipc_wake_src_t;
endpackage
`default_nettype wire

// ===== ipc_wake_model.sv
// Behavioural model of the wake and reset sources around the power controller.
`timescale 1ns/100ps
`default_nettype none
module ipc_wake_model (
	// Clock.
	input wire logic pclk,
	// One event line per source, high for one cycle.
	output var logic [10:0] src
);
	// ****************************************
	// Event generation.
	// ****************************************
	logic bod_armed;

	initial src = 11'h000;
	initial bod_armed = 1'b0;

	// Events rise and fall just after an edge, so every event is seen for exactly one cycle.
	// The keyboard line idles high, so its event is the falling edge away from that level.
	// A brown-out event is only produced when the test arms it first.
	task automatic fire(input int i);
		if ((i == 3 || i == 8) && !bod_armed) begin
			return;
		end
		@(posedge pclk);
		src[i] <= 1'b1;
		@(posedge pclk);
		src[i] <= 1'b0;
	endtask

	// Brown-out detection is switched on before power-down is entered.
	task automatic arm_bod();
		bod_armed = 1'b1;
	endtask
endmodule // ipc_wake_model
`default_nettype wire

// ===== idle_powerdown_control_tb_top.sv
// Self-checking testbench of the idle and power-down controller.
`timescale 1ns/100ps
`default_nettype none
module idle_powerdown_control_tb_top;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic global_int_enable;
	logic [10:0] src;
	ipc_pkg::ipc_clk_ctl_t clk_ctl;
	logic wd_clear;
	ipc_pkg::ipc_wake_src_t wake_src;
	logic cold_init;
	logic [7:0] power_control;
	logic irq;
	logic [31:0] rd_seen;
	logic err_seen;
	int n_errors = 0;
	int cmp_count = 0;
	int n_clr = 0;
	logic [5:0] ws_seen = 6'h00;
	logic cold_seen = 1'b0;
	logic [1:0] ext_en;
	int srcs [9] = '{4, 5, 0, 1, 2, 3, 6, 7, 8};
	logic [5:0] wss [9] = '{6'h02, 6'h00, 6'h20, 6'h10, 6'h08, 6'h04, 6'h00, 6'h01, 6'h01};

	ipc_power_ctrl i_ipc_power_ctrl (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_int({2{src[0]}}), .ext_int_en(ext_en), .global_int_enable(global_int_enable),
		.keyboard_interrupt({8{~src[1]}}), .wdt_irq(src[2]), .bod_irq(src[3]),
		.irq_pending(src[4]), .pin_reset(src[5]), .por_reset(src[6]), .wdt_reset(src[7]),
		.bod_reset(src[8]), .soft_reset(src[9]), .por_done(src[10]), .clk_ctl(clk_ctl),
		.watchdog_counter_clear(wd_clear), .wake_src(wake_src), .cold_init(cold_init),
		.power_control(power_control), .irq(irq)
	);

	ipc_wake_model i_ipc_wake_model (.pclk(pclk), .src(src));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// Counter-clear pulses are counted, so a doubled or missing one shows up; wake sources and cold init are only collected.
	always @(posedge pclk) begin
		n_clr += (wd_clear === 1'b1);
		ws_seen |= wake_src;
		cold_seen |= (cold_init === 1'b1);
	end

	// ****************************************
	// Bus and checking tasks.
	// ****************************************
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", s, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Each transfer starts one edge after the last release, so no signal is driven twice.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1) begin
			n_errors++;
			stop_test();
		end
		rd_seen = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input string s, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(s, rd_seen, e);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task automatic pulses(input logic [31:0] clr, input logic [31:0] ws, input logic [31:0] cold);
		chk("counter clears", n_clr, clr);
		chk("wake source", ws_seen, ws);
		chk("cold init", cold_seen, cold);
		n_clr = 0;
		ws_seen = 6'h00;
		cold_seen = 1'b0;
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		stop_test();
	end

	// ****************************************
	// Test sequence.
	// ****************************************
	initial begin
		int i;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		global_int_enable = 1'b0;
		ext_en = 2'b01;
		presetn = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd("control at reset", ipc_pkg::POWER_CONTROL_ADDR, 32'h0);
		chk("clocks at reset", clk_ctl, 32'h3c);
		apb(1'b1, 12'hffc, 32'h1);
		chk("unmapped error", err_seen, 32'h1);
		rd("unmapped data", 12'hffc, 32'h0);
		apb(1'b1, ipc_pkg::POWER_CONTROL_ADDR, 32'hec);
		rd("general flags", ipc_pkg::POWER_CONTROL_ADDR, 32'hcc);
		i_ipc_wake_model.fire(10);
		settle(2);
		rd("cold flag set", ipc_pkg::POWER_CONTROL_ADDR, 32'hdc);
		apb(1'b1, ipc_pkg::POWER_CONTROL_ADDR, 32'h0);
		rd("cold flag cleared", ipc_pkg::POWER_CONTROL_ADDR, 32'h0);
		apb(1'b1, ipc_pkg::KEY_MASK_ADDR, 32'h1);
		i_ipc_wake_model.arm_bod();
		// Two idle wakes, then every power-down wake but the pin reset; the first power-down sets both bits.
		for (i = 0; i < 9; i++) begin
			apb(1'b1, ipc_pkg::POWER_CONTROL_ADDR, i < 2 ? 32'h1 : (i == 2 ? 32'h3 : 32'h2));
			settle(2);
			chk("low power clocks", clk_ctl, i < 2 ? 32'h3b : 32'h03);
			pulses(1, 0, 0);
			i_ipc_wake_model.fire(9);
			if (i >= 2) begin
				i_ipc_wake_model.fire(4);
				i_ipc_wake_model.fire(0);
				ext_en <= 2'b00;
				global_int_enable <= 1'b1;
				i_ipc_wake_model.fire(0);
			end
			settle(3);
			chk("refused wake", clk_ctl, i < 2 ? 32'h3b : 32'h03);
			@(posedge pclk);
			global_int_enable <= 1'b1;
			ext_en <= 2'b01;
			i_ipc_wake_model.fire(srcs[i]);
			settle(3);
			chk("woken clocks", clk_ctl, 32'h3c);
			chk("request bits", power_control[1:0], 32'h0);
			pulses(1, wss[i], srcs[i] == 5 || srcs[i] == 6);
			@(posedge pclk);
			global_int_enable <= 1'b0;
		end
		chk("masked irq", irq, 32'h0);
		apb(1'b1, ipc_pkg::IRQ_ENABLE_ADDR, 32'h2);
		settle(2);
		chk("raised irq", irq, 32'h1);
		rd("enable", ipc_pkg::IRQ_ENABLE_ADDR, 32'h2);
		apb(1'b1, ipc_pkg::IRQ_CLEAR_ADDR, 32'h7);
		settle(2);
		chk("cleared irq", irq, 32'h0);
		rd("status", ipc_pkg::IRQ_STATUS_ADDR, 32'h0);
		rd("clear reads", ipc_pkg::IRQ_CLEAR_ADDR, 32'h0);
		stop_test();
	end
endmodule // idle_powerdown_control_tb_top
`default_nettype wire
